// ===== inc/adcs_regs.svh
// Constants for the two-wire slave front end of the multichannel ADC.
// Assumes inclusion by bare name from the two-wire slave core file.
`ifndef ADCS_REGS_SVH
`define ADCS_REGS_SVH

// ****************************************************************
// Setup byte layout
// ****************************************************************
`define ADCS_SETUP_REG_BIT 7
`define ADCS_SETUP_REF_HI 6
`define ADCS_SETUP_REF_LO 4
`define ADCS_SETUP_CLK_BIT 3
`define ADCS_SETUP_POL_BIT 2
`define ADCS_SETUP_RST_BIT 1
`define ADCS_SETUP_RESET 3'h0
`define ADCS_SETUP_CLK_RESET 1'h0
`define ADCS_SETUP_POL_RESET 1'h0

// ****************************************************************
// Configuration byte layout (only the fields this block keeps)
// ****************************************************************
`define ADCS_CFG_SCAN_HI 6
`define ADCS_CFG_SCAN_LO 5
`define ADCS_CFG_CS_HI 4
`define ADCS_CFG_CS_LO 1
`define ADCS_CFG_PAIR_BIT 0
`define ADCS_CFG_RESET 7'h01

// ****************************************************************
// Bus codes
// ****************************************************************
`define ADCS_HS_CODE_PREFIX 5'h01
`define ADCS_BYTE_BITS 4'h8

`endif

// ===== inc/adcs_pkg.sv
// Types shared by the two-wire slave and the result coder.
// Assumes adcs_regs.svh is on the include path.
package adcs_pkg;

	// Link side protocol states
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ADDR_ACK = 3'b010,
		ST_WRITE = 3'b011,
		ST_WRITE_ACK = 3'b100,
		ST_READ = 3'b101,
		ST_READ_ACK = 3'b110
	} adcs_state_e;

	// Setup register fields
	typedef struct packed
	{
		logic [2:0] refSelect;
		logic clockSource;
		logic polarity;
	} adcs_setup_s;

	// Configuration register fields kept here
	typedef struct packed
	{
		logic [1:0] scanMode;
		logic [3:0] channelSelect;
		logic inputPairing;
	} adcs_cfg_s;

	// One raw conversion, both inputs against ground
	typedef struct packed
	{
		logic [7:0] posInput;
		logic [7:0] negInput;
	} adcs_conv_s;

endpackage

// ===== core/adcs_result_coder.sv
// Result coding for one conversion: pairing and polarity shape the code.
// Assumes raw inputs are straight codes of each input against ground.
module adcs_result_coder
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic inputPairing,
	input wire logic polarity,
	input wire adcs_pkg::adcs_conv_s conv,
	input wire logic convValid,
	output logic [7:0] code,
	output logic codeValid
);

	// ****************************************************************
	// Coding
	// ****************************************************************

	// Nine-bit signed difference of the positive and negative inputs
	wire logic signed [8:0] diff;
	wire logic diffNeg;
	wire logic [7:0] uniCode;
	wire logic [7:0] bipCode;
	wire logic [7:0] next_code;

	assign diff = $signed({1'b0, conv.posInput}) -
		$signed({1'b0, conv.negInput});
	assign diffNeg = diff[8];
	// Negative difference in unipolar mode pins the code at zero
	assign uniCode = diffNeg ? 8'h00 : diff[7:0];
	// Bipolar spans half the reference either side, saturated to 8 bits
	assign bipCode = (diff > 9'sh07F) ? 8'h7F :
		(diff < -9'sh080) ? 8'h80 : diff[7:0];
	// Single-ended: against ground and always unipolar, polarity ignored
	assign next_code = inputPairing ? conv.posInput :
		(polarity ? bipCode : uniCode);

	// Result register and its valid pulse
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			code <= 8'h00;
			codeValid <= 1'b0;
		end
		else
		begin
			codeValid <= convValid;
			if (convValid)
				code <= next_code;
		end
	end

endmodule

// ===== core/adcs_two_wire_slave.sv
// Two-wire slave front end of a multichannel 8-bit ADC: bus protocol on
// the link clock, setup and configuration state and result coding on clk.
// Assumes open-drain SDA with a pull-up; SCL is only ever an input here.
//
// Operation
// - Single-ended mode: result is the selected input against ground.
// - Pseudo-differential mode: result is positive minus negative input.
// - Unipolar: negative difference gives code zero.
// - Straight binary when unipolar, two's complement when bipolar.
// - Single-ended always codes unipolar, polarity bit ignored.
// - Setup bit 2 selects bipolar, resets to unipolar.
// - Setup bit 1 at zero restores configuration defaults only.
// - One bit per SCL cycle, nine cycles per byte with acknowledge.
// - SDA changes while SCL high are start or stop, not data.
// - Both lines idle high; device releases SDA when not busy.
// - Repeated start keeps bus active and timing mode unchanged.
// - Receiver acknowledges by holding SDA low through ninth pulse.
// - Receiver not-acknowledges by releasing SDA through ninth pulse.
// - Idle device waits for start plus own address before data.
// - Responds to one fixed 7-bit address.
// - Address LSB: zero is write, one is read.
// - Matching address is acknowledged for one clock cycle.
// - Powers up in fast/standard timing mode.
// - Written byte MSB set is setup, clear is configuration.
// - Clock source bit resets to internal, one selects SCL.
// - High-speed master code is not acknowledged, stop ends it.
`include "adcs_regs.svh"

module adcs_two_wire_slave
#(
	// Arbitrary value; the real one is fixed per variant at manufacture
	parameter logic [6:0] SLAVE_ADDR = 7'h2A
)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic linkClk,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaDriveEn_b,
	input wire adcs_pkg::adcs_conv_s conv,
	input wire logic convValid,
	output adcs_pkg::adcs_setup_s setup,
	output adcs_pkg::adcs_cfg_s cfg,
	output logic highSpeed,
	output logic [7:0] resultCode,
	output logic resultValid
);

	// ****************************************************************
	// Link side: pin synchronisers and bus conditions
	// ****************************************************************

	logic sclMeta;
	logic sclSync;
	logic sclPrev;
	logic sdaMeta;
	logic sdaSync;
	logic sdaPrev;

	// Two flops per pin before any logic; a third copy for edges
	always_ff @(posedge linkClk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sclMeta <= 1'b1;
			sclSync <= 1'b1;
			sclPrev <= 1'b1;
			sdaMeta <= 1'b1;
			sdaSync <= 1'b1;
			sdaPrev <= 1'b1;
		end
		else
		begin
			sclMeta <= sclIn;
			sclSync <= sclMeta;
			sclPrev <= sclSync;
			sdaMeta <= sdaIn;
			sdaSync <= sdaMeta;
			sdaPrev <= sdaSync;
		end
	end

	wire logic startSeen;
	wire logic stopSeen;
	wire logic sclRise;
	wire logic sclFall;

	// SDA moving while SCL stays high is a control condition
	assign startSeen = sclSync & sclPrev & sdaPrev & ~sdaSync;
	assign stopSeen = sclSync & sclPrev & ~sdaPrev & sdaSync;
	assign sclRise = sclSync & ~sclPrev;
	assign sclFall = ~sclSync & sclPrev;

	// ****************************************************************
	// Link side: byte engine
	// ****************************************************************

	adcs_pkg::adcs_state_e state;
	logic [7:0] rxShift;
	logic [7:0] txShift;
	logic [3:0] bitCount;
	logic readDir;
	logic masterAck;
	logic sdaLow;
	logic hsMode;
	logic [7:0] linkResult;

	wire logic byteDone;
	wire logic addrMatch;
	wire logic hsCode;
	wire logic rxIsSetup;

	assign byteDone = (bitCount == `ADCS_BYTE_BITS);
	assign addrMatch = (rxShift[7:1] == SLAVE_ADDR);
	assign hsCode = (rxShift[7:3] == `ADCS_HS_CODE_PREFIX);
	assign rxIsSetup = rxShift[`ADCS_SETUP_REG_BIT];

	// Protocol sequencer; a start from any state restarts addressing
	always_ff @(posedge linkClk or negedge rst_b)
	begin
		if (!rst_b)
			state <= adcs_pkg::ST_IDLE;
		else if (startSeen)
			state <= adcs_pkg::ST_ADDR;
		else if (stopSeen)
			state <= adcs_pkg::ST_IDLE;
		else if (sclFall)
		begin
			unique case (state)
				adcs_pkg::ST_IDLE:
					state <= adcs_pkg::ST_IDLE;
				adcs_pkg::ST_ADDR:
					if (byteDone)
						state <= addrMatch ? adcs_pkg::ST_ADDR_ACK :
							adcs_pkg::ST_IDLE;
				adcs_pkg::ST_ADDR_ACK:
					state <= readDir ? adcs_pkg::ST_READ :
						adcs_pkg::ST_WRITE;
				adcs_pkg::ST_WRITE:
					if (byteDone)
						state <= adcs_pkg::ST_WRITE_ACK;
				adcs_pkg::ST_WRITE_ACK:
					state <= adcs_pkg::ST_WRITE;
				adcs_pkg::ST_READ:
					if (byteDone)
						state <= adcs_pkg::ST_READ_ACK;
				adcs_pkg::ST_READ_ACK:
					state <= masterAck ? adcs_pkg::ST_READ :
						adcs_pkg::ST_IDLE;
				default:
					state <= adcs_pkg::ST_IDLE;
			endcase
		end
	end

	wire logic inByte;
	assign inByte = (state == adcs_pkg::ST_ADDR) |
		(state == adcs_pkg::ST_WRITE) | (state == adcs_pkg::ST_READ);

	// Bit counter: one bit per SCL rise, cleared at each byte boundary
	always_ff @(posedge linkClk or negedge rst_b)
	begin
		if (!rst_b)
			bitCount <= 4'h0;
		else if (startSeen | (sclFall & (~inByte | byteDone)))
			bitCount <= 4'h0;
		else if (sclRise & inByte)
			bitCount <= bitCount + 4'h1;
	end

	// Receive shifter samples SDA on SCL rise, where it is stable
	always_ff @(posedge linkClk or negedge rst_b)
	begin
		if (!rst_b)
			rxShift <= 8'h00;
		else if (sclRise & inByte)
			rxShift <= {rxShift[6:0], sdaSync};
	end

	// Direction bit and the master's answer after each read byte
	always_ff @(posedge linkClk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			readDir <= 1'b0;
			masterAck <= 1'b0;
		end
		else
		begin
			if (sclFall & (state == adcs_pkg::ST_ADDR) & byteDone)
				readDir <= rxShift[0];
			if (sclRise & (state == adcs_pkg::ST_READ_ACK))
				masterAck <= ~sdaSync;
		end
	end

	// Transmit shifter: loaded at the end of a read's address acknowledge and of each read byte the master acknowledges
	wire logic txLoad;
	assign txLoad = sclFall & (((state == adcs_pkg::ST_ADDR_ACK) &
		readDir) | ((state == adcs_pkg::ST_READ_ACK) & masterAck));

	always_ff @(posedge linkClk or negedge rst_b)
	begin
		if (!rst_b)
			txShift <= 8'hFF;
		else if (txLoad)
			txShift <= linkResult;
		else if (sclFall & (state == adcs_pkg::ST_READ) & ~byteDone)
			txShift <= {txShift[6:0], 1'b1};
	end

	// SDA pull-down: acknowledge slots and zero data bits while reading.
	// Changes only after SCL falls, so SDA is steady across SCL high.
	wire logic next_sdaLow;
	wire logic ackAddr;
	wire logic ackWrite;
	assign ackAddr = (state == adcs_pkg::ST_ADDR) & byteDone &
		addrMatch;
	assign ackWrite = (state == adcs_pkg::ST_WRITE) & byteDone;
	assign next_sdaLow = ackAddr | ackWrite | (txLoad & ~linkResult[7]) |
		((state == adcs_pkg::ST_READ) & ~byteDone & ~txShift[6]);

	always_ff @(posedge linkClk or negedge rst_b)
	begin
		if (!rst_b)
			sdaLow <= 1'b0;
		else if (startSeen | stopSeen)
			sdaLow <= 1'b0;
		else if (sclFall)
			sdaLow <= next_sdaLow;
	end

	// Open drain: only ever drive low, release otherwise
	assign sdaOut = 1'b0;
	assign sdaDriveEn_b = ~sdaLow;

	// High-speed timing: entered on the master code, left on stop only.
	// The master code gets no pull-down, so it is not acknowledged.
	always_ff @(posedge linkClk or negedge rst_b)
	begin
		if (!rst_b)
			hsMode <= 1'b0;
		else if (stopSeen)
			hsMode <= 1'b0;
		else if (sclFall & (state == adcs_pkg::ST_ADDR) & byteDone & hsCode)
			hsMode <= 1'b1;
	end

	// ****************************************************************
	// Link side: setup and configuration writes
	// ****************************************************************

	adcs_pkg::adcs_setup_s linkSetup;
	adcs_pkg::adcs_cfg_s linkCfg;
	logic writeToggle;

	wire logic byteWritten;
	assign byteWritten = sclFall & ackWrite;

	// Setup and configuration registers; setup bit 0 is never stored
	always_ff @(posedge linkClk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			linkSetup.refSelect <= `ADCS_SETUP_RESET;
			linkSetup.clockSource <= `ADCS_SETUP_CLK_RESET;
			linkSetup.polarity <= `ADCS_SETUP_POL_RESET;
			linkCfg <= `ADCS_CFG_RESET;
		end
		else if (byteWritten & rxIsSetup)
		begin
			linkSetup.refSelect <=
				rxShift[`ADCS_SETUP_REF_HI:`ADCS_SETUP_REF_LO];
			linkSetup.clockSource <= rxShift[`ADCS_SETUP_CLK_BIT];
			linkSetup.polarity <= rxShift[`ADCS_SETUP_POL_BIT];
			if (!rxShift[`ADCS_SETUP_RST_BIT])
				linkCfg <= `ADCS_CFG_RESET;
		end
		else if (byteWritten)
			linkCfg <= rxShift[6:0];
	end

	// Event toggle announcing new register contents to the clk side
	always_ff @(posedge linkClk or negedge rst_b)
	begin
		if (!rst_b)
			writeToggle <= 1'b0;
		else if (byteWritten)
			writeToggle <= ~writeToggle;
	end

	// ****************************************************************
	// Link to clk crossing
	// ****************************************************************

	logic wrTglMeta;
	logic wrTglSync;
	logic wrTglPrev;
	logic hsMeta;

	// Register words are held for a whole byte time after the toggle,
	// far longer than the three clk cycles the capture needs.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wrTglMeta <= 1'b0;
			wrTglSync <= 1'b0;
			wrTglPrev <= 1'b0;
			hsMeta <= 1'b0;
			highSpeed <= 1'b0;
		end
		else
		begin
			wrTglMeta <= writeToggle;
			wrTglSync <= wrTglMeta;
			wrTglPrev <= wrTglSync;
			hsMeta <= hsMode;
			highSpeed <= hsMeta;
		end
	end

	// Captured copies of the setup and configuration registers
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			setup.refSelect <= `ADCS_SETUP_RESET;
			setup.clockSource <= `ADCS_SETUP_CLK_RESET;
			setup.polarity <= `ADCS_SETUP_POL_RESET;
			cfg <= `ADCS_CFG_RESET;
		end
		else if (wrTglSync ^ wrTglPrev)
		begin
			setup <= linkSetup;
			cfg <= linkCfg;
		end
	end

	// ****************************************************************
	// Result coding on clk
	// ****************************************************************

	adcs_result_coder u_coder
	(
		.clk(clk),
		.rst_b(rst_b),
		.inputPairing(cfg.inputPairing),
		.polarity(setup.polarity),
		.conv(conv),
		.convValid(convValid),
		.code(resultCode),
		.codeValid(resultValid)
	);

	// ****************************************************************
	// clk to link crossing of the latest result
	// ****************************************************************

	logic resToggle;
	logic [7:0] resHold;
	logic resTglMeta;
	logic resTglSync;
	logic resTglPrev;

	// Hold word stays put until the next result; results must be spaced
	// by at least four link clocks for the capture to see a stable word.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			resToggle <= 1'b0;
			resHold <= 8'h00;
		end
		else if (resultValid)
		begin
			resToggle <= ~resToggle;
			resHold <= resultCode;
		end
	end

	always_ff @(posedge linkClk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			resTglMeta <= 1'b0;
			resTglSync <= 1'b0;
			resTglPrev <= 1'b0;
			linkResult <= 8'h00;
		end
		else
		begin
			resTglMeta <= resToggle;
			resTglSync <= resTglMeta;
			resTglPrev <= resTglSync;
			if (resTglSync ^ resTglPrev)
				linkResult <= resHold;
		end
	end

endmodule

// ===== tb/adcs_sva.sv
// Checker for the two-wire slave: result coding and SDA driving.
// Assumes it is bound to adcs_two_wire_slave and sees only its ports.
module adcs_sva
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic linkClk,
	input wire logic sclIn,
	input wire logic sdaDriveEn_b,
	input wire adcs_pkg::adcs_conv_s conv,
	input wire logic convValid,
	input wire adcs_pkg::adcs_setup_s setup,
	input wire adcs_pkg::adcs_cfg_s cfg,
	input wire logic [7:0] resultCode,
	input wire logic resultValid
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// Expected codes
	// ****************************************************************
	// Nine bits wide so the borrow of a negative difference survives
	logic signed [8:0] diffS;
	logic [7:0] uniExp;
	logic [7:0] bipExp;
	assign diffS = $signed({1'b0, conv.posInput}) -
		$signed({1'b0, conv.negInput});
	assign uniExp = diffS[8] ? 8'h00 : diffS[7:0];
	assign bipExp = (diffS > 9'sd127) ? 8'h7F :
		(diffS < -9'sd128) ? 8'h80 : diffS[7:0];

	// ****************************************************************
	// Properties
	// ****************************************************************
	property p_result_follows;
		@(posedge clk) disable iff (!rst_b)
		convValid |=> resultValid;
	endproperty
	a_result_follows: assert property (p_result_follows)
		else $error("result missing after conversion");

	property p_valid_cause;
		@(posedge clk) disable iff (!rst_b)
		resultValid |-> $past(convValid);
	endproperty
	a_valid_cause: assert property (p_valid_cause)
		else $error("result without conversion");

	property p_single_ended;
		@(posedge clk) disable iff (!rst_b)
		convValid && cfg.inputPairing |=> resultCode == $past(conv.posInput);
	endproperty
	a_single_ended: assert property (p_single_ended)
		else $error("single-ended code wrong");

	property p_unipolar;
		@(posedge clk) disable iff (!rst_b)
		convValid && !cfg.inputPairing && !setup.polarity
			|=> resultCode == $past(uniExp);
	endproperty
	a_unipolar: assert property (p_unipolar)
		else $error("unipolar code wrong");

	property p_bipolar;
		@(posedge clk) disable iff (!rst_b)
		convValid && !cfg.inputPairing && setup.polarity
			|=> resultCode == $past(bipExp);
	endproperty
	a_bipolar: assert property (p_bipolar)
		else $error("bipolar code wrong");

	property p_ack_len;
		@(posedge linkClk) disable iff (!rst_b)
		$fell(sdaDriveEn_b) |-> !sdaDriveEn_b [*8];
	endproperty
	a_ack_len: assert property (p_ack_len)
		else $error("SDA pull shorter than a bit");

	property p_drive_bounded;
		@(posedge linkClk) disable iff (!rst_b)
		$fell(sdaDriveEn_b) |-> ##[1:400] sdaDriveEn_b;
	endproperty
	a_drive_bounded: assert property (p_drive_bounded)
		else $error("SDA held low too long");

	property p_sda_scl_low;
		@(posedge linkClk) disable iff (!rst_b)
		$changed(sdaDriveEn_b) |-> !sclIn;
	endproperty
	a_sda_scl_low: assert property (p_sda_scl_low)
		else $error("SDA moved while SCL high");
endmodule

bind adcs_two_wire_slave adcs_sva i_sva
(
	.clk(clk),
	.rst_b(rst_b),
	.linkClk(linkClk),
	.sclIn(sclIn),
	.sdaDriveEn_b(sdaDriveEn_b),
	.conv(conv),
	.convValid(convValid),
	.setup(setup),
	.cfg(cfg),
	.resultCode(resultCode),
	.resultValid(resultValid)
);

// ===== tb/adcs_tb_master.sv
// Behavioural bus master that clocks SCL and shares SDA with the slave.
// Assumes pull-ups on both lines; timed in clk cycles of the bench.
module adcs_tb_master
(
	input wire logic clk,
	input wire logic sdaDriveEn_b,
	output logic sclIn,
	output logic sdaIn
);
	timeunit 1ns;
	timeprecision 1ps;
	// Half SCL period, well above the slave's minimum high time
	localparam int HALF = 40;
	logic sdaLow = 1'b0;
	logic sclHigh = 1'b1;

	// Pulled-up lines; either party may pull SDA low
	assign sclIn = sclHigh;
	assign sdaIn = ~(sdaLow | ~sdaDriveEn_b);

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Also a repeated start, since SDA is released first
	task automatic start();
		wt(4);
		sdaLow <= 1'b0;
		wt(HALF);
		sclHigh <= 1'b1;
		wt(HALF);
		sdaLow <= 1'b1;
		wt(HALF);
		sclHigh <= 1'b0;
	endtask

	task automatic stop();
		wt(4);
		sdaLow <= 1'b1;
		wt(HALF);
		sclHigh <= 1'b1;
		wt(HALF);
		sdaLow <= 1'b0;
		wt(HALF);
	endtask

	// SDA set only while SCL low; sampled late in the high phase
	task automatic clock_bit(input logic b, output logic r);
		wt(4);
		sdaLow <= ~b;
		wt(HALF - 4);
		sclHigh <= 1'b1;
		wt(HALF);
		r = sdaIn;
		sclHigh <= 1'b0;
	endtask

	// Eight bits MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic ackBit,
		output logic [7:0] q, output logic acked);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			clock_bit(d[i], r);
			q[i] = r;
		end
		clock_bit(ackBit, r);
		acked = ~r;
	endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the two-wire slave and its result coder.
// Assumes adcs_tb_master on the bus and the checker bound to the design.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] ADDR = 7'h2A;
	// Setup, configuration, positive, negative, expected code
	localparam logic [39:0] CASES [5] = '{40'h86_01_90_10_90,
		40'h82_00_50_20_30, 40'h82_00_20_50_00,
		40'h86_00_20_50_D0, 40'h86_00_F0_00_7F};
	logic clk = 1'b0;
	logic linkClk = 1'b0;
	logic rst_b = 1'b0;
	logic convValid = 1'b0;
	adcs_pkg::adcs_conv_s conv = '0;
	logic sclIn, sdaIn, sdaDriveEn_b, highSpeed, resultValid, a;
	logic sdaOut;
	logic [7:0] resultCode, q;
	adcs_pkg::adcs_setup_s setup;
	adcs_pkg::adcs_cfg_s cfg;
	int n_mismatch = 0;
	int compares = 0;

	always #2.5 clk = ~clk;
	// Link clock with a phase unrelated to clk
	initial
	begin
		#3;
		forever #16 linkClk = ~linkClk;
	end

	adcs_two_wire_slave #(.SLAVE_ADDR(ADDR)) i_dut
	(
		.clk(clk), .rst_b(rst_b), .linkClk(linkClk), .sclIn(sclIn),
		.sdaIn(sdaIn), .sdaOut(sdaOut), .sdaDriveEn_b(sdaDriveEn_b),
		.conv(conv), .convValid(convValid), .setup(setup), .cfg(cfg),
		.highSpeed(highSpeed), .resultCode(resultCode),
		.resultValid(resultValid)
	);

	adcs_tb_master i_master
	(
		.clk(clk), .sdaDriveEn_b(sdaDriveEn_b), .sclIn(sclIn), .sdaIn(sdaIn)
	);

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Addressed write of two bytes, each acknowledged
	task automatic wr2(input logic [7:0] b0, input logic [7:0] b1);
		i_master.start();
		i_master.xfer({ADDR, 1'b0}, 1'b1, q, a);
		chk({7'h0, a}, 8'h01);
		i_master.xfer(b0, 1'b1, q, a);
		chk({7'h0, a}, 8'h01);
		i_master.xfer(b1, 1'b1, q, a);
		chk({7'h0, a}, 8'h01);
		i_master.stop();
		repeat (40) @(posedge clk);
	endtask

	task automatic convert(input logic [7:0] p, input logic [7:0] n,
		input logic [7:0] e);
		@(posedge clk);
		conv <= {p, n};
		convValid <= 1'b1;
		@(posedge clk);
		convValid <= 1'b0;
		#1;
		chk({7'h0, resultValid}, 8'h01);
		chk(resultCode, e);
	endtask

	task automatic give_verdict();
		$display("Counts: compares=%0d mismatches=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Cuts a hang short, under three times the expected run
	initial
	begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		give_verdict();
	end

	initial
	begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		chk({3'h0, setup}, 8'h00);
		chk({1'h0, cfg}, 8'h01);
		chk({7'h0, highSpeed}, 8'h00);
		chk({7'h0, sdaDriveEn_b}, 8'h01);
		chk({7'h0, sdaOut}, 8'h00);
		$display("test reset done");
		repeat (10) @(posedge clk);
		i_master.start();
		i_master.xfer({ADDR ^ 7'h01, 1'b0}, 1'b1, q, a);
		chk({7'h0, a}, 8'h00);
		i_master.stop();
		wr2(8'hBF, 8'h3C);
		chk({3'h0, setup}, 8'h0F);
		chk({1'h0, cfg}, 8'h3C);
		wr2(8'h3C, 8'hC0);
		chk({3'h0, setup}, 8'h10);
		chk({1'h0, cfg}, 8'h01);
		$display("test setup writes done");
		for (int i = 0; i < 5; i++)
		begin
			wr2(CASES[i][39:32], CASES[i][31:24]);
			convert(CASES[i][23:16], CASES[i][15:8], CASES[i][7:0]);
		end
		$display("test result coding done");
		i_master.start();
		i_master.xfer({ADDR, 1'b1}, 1'b1, q, a);
		chk({7'h0, a}, 8'h01);
		i_master.xfer(8'hFF, 1'b0, q, a);
		chk(q, 8'h7F);
		i_master.xfer(8'hFF, 1'b1, q, a);
		chk(q, 8'h7F);
		i_master.stop();
		chk({7'h0, sdaDriveEn_b}, 8'h01);
		$display("test read done");
		i_master.start();
		i_master.xfer(8'h08, 1'b1, q, a);
		chk({7'h0, a}, 8'h00);
		repeat (20) @(posedge clk);
		chk({7'h0, highSpeed}, 8'h01);
		i_master.start();
		i_master.xfer({ADDR, 1'b0}, 1'b1, q, a);
		chk({7'h0, a}, 8'h01);
		chk({7'h0, highSpeed}, 8'h01);
		i_master.stop();
		repeat (20) @(posedge clk);
		chk({7'h0, highSpeed}, 8'h00);
		$display("test high-speed mode done");
		give_verdict();
	end
endmodule
